// >>> rtl/mcd_cfg.svh
// constants for the machine check and vector dispatch unit
`ifndef MCD_CFG_SVH
`define MCD_CFG_SVH

// ==========================================
// priority levels
`define IPL_MAX         5'h1f
`define IPL_SYS_COR     5'h14
`define IPL_ASYNC       5'h02

// ==========================================
// vector control block byte offsets
`define OFF_FEN         15'h0010
`define OFF_ACV         15'h0080
`define OFF_TNV         15'h0090
`define OFF_FOR         15'h00a0
`define OFF_FOW         15'h00b0
`define OFF_FOE         15'h00c0
`define OFF_ARITH       15'h0200
`define OFF_ASYNC_K     15'h0240
`define OFF_ASYNC_E     15'h0250
`define OFF_ASYNC_S     15'h0260
`define OFF_SYS_COR     15'h0620
`define OFF_PROC_COR    15'h0630
`define OFF_SYS_MCHK    15'h0660
`define OFF_PROC_MCHK   15'h0670
`define OFF_PARAM       48'h0000_0000_0008

// ==========================================
// error summary bit positions
`define ES_MCHK_IP      0
`define ES_SYS_COR_IP   1
`define ES_PROC_COR_IP  2
`define ES_SUP_PROC     3
`define ES_SUP_SYS      4

// ==========================================
// logout frame
`define FLG_RETRY       31
`define FLG_SECOND      30
`define FRM_FW_OFF      32'h0000_0010
`define LOGOUT_NONE     64'hffff_ffff_ffff_ffff

`endif

// >>> rtl/mcd_pkg.sv
// types for the machine check and vector dispatch unit
package mcd_pkg;

   // ==========================================
   // fault and trap kinds
   typedef enum logic [3:0] {
      FLT_FEN, FLT_ACV, FLT_TNV, FLT_FOR, FLT_FOW, FLT_FOE,
      TRP_ARITH, TRP_ASYNC_K, TRP_ASYNC_E, TRP_ASYNC_S
   } trap_kind_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RD_VEC, ST_RD_PARM, ST_DONE, ST_CONSOLE
   } disp_state_t;

   // ==========================================
   // carriers
   typedef struct packed {
      logic [63:0] handler_pc;
      logic [63:0] param;
      logic [63:0] saved_pc;
      logic [63:0] logout_ptr;
      logic [4:0]  ipl;
      logic        kernel;
   } dispatch_t;

   typedef struct packed {
      logic [31:0] size;
      logic [31:0] flags;
      logic [31:0] cpu_off;
      logic [31:0] sys_off;
   } frame_hdr_t;

   typedef struct packed {
      logic [31:0] fw_len;
      logic [31:0] cpu_len;
      logic [31:0] sys_len;
   } frame_len_t;

endpackage : mcd_pkg

// >>> rtl/sticky_flags.sv
// bank of sticky flags where a set beats a clear
`timescale 1ns/10ps
`default_nettype none

module sticky_flags #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic         ce_in,
   // controls
   input  wire logic [W-1:0] set_in,
   input  wire logic [W-1:0] clr_in,
   // state
   output logic      [W-1:0] q_out
);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         q_out <= '0;
      end else if (ce_in) begin
         q_out <= set_in | (q_out & ~clr_in);
      end
   end

   set_beats_clr_a: assert property (@(posedge clk_in) disable iff (rst_in) // RL10
      ce_in |=> ((q_out & $past(set_in)) == $past(set_in)))
      else $error("flag set lost to a clear");

endmodule : sticky_flags

`default_nettype wire

// >>> rtl/vec_entry_addr.sv
// entry address from page frame base and byte offset
`timescale 1ns/10ps
`default_nettype none

module vec_entry_addr #(
   parameter int ADDR_W     = 48,
   parameter int PAGE_SHIFT = 13
) (
   // inputs
   input  wire logic [ADDR_W-PAGE_SHIFT-1:0] pfn_in,
   input  wire logic [14:0]                  off_in,
   // result
   output logic      [ADDR_W-1:0]            addr_out
);

   logic [10:0] idx;

   // base plus entry index times sixteen
   assign idx      = off_in[14:4];
   assign addr_out = {pfn_in, {PAGE_SHIFT{1'b0}}}
                   + {{(ADDR_W-15){1'b0}}, idx, 4'h0}; // RL24 RL17

endmodule : vec_entry_addr

`default_nettype wire

// >>> rtl/mchk_dispatch.sv
// machine check delivery and vector dispatch unit
//
// What this block does
// RL1 - processor correctable checks at level 31; nonmaskable at once, maskable below 31
// RL2 - every machine check enters kernel mode on kernel stack, never disabled
// RL3 - suppression bits stop reporting of corrections, not generation or correction
// RL4 - saved pc is the next instruction that would have issued
// RL5 - drain-aborts call holds issue until outstanding checks are taken
// RL6 - retry flag set only when processor and platform state are intact
// RL7 - one detected error condition yields only one machine check
// RL8 - uncorrectable in-progress flag set before check; software clears it
// RL9 - second uncorrectable error or failed delivery enters console, double error
// RL10 - correctable in-progress flag set before report; software clears it
// RL11 - correctable error during in-progress is corrected, unreported, frame untouched
// RL12 - logout pointer holds frame offset, or all ones when no frame
// RL13 - frame holds size, flags, cpu offset, system offset, firmware info
// RL14 - flag bit 31 resume indication, always set on corrected reports
// RL15 - flag bit 30 second correctable error; clear on checks; low bits zero
// RL16 - offsets of 16, equal offsets, or size mark absent sections
// RL17 - vector block page aligned, base from vector table base page frame
// RL18 - entries of sixteen bytes: handler address then parameter
// RL19 - first 512 entries are static; rest are software assigned
// RL20 - faults in kernel mode, level unchanged, at their fault offsets
// RL21 - arithmetic trap at offset 200, kernel mode, level unchanged
// RL22 - async system traps at level 2, kernel, offsets 240 250 260
// RL23 - each dispatch reads its entry before handing over control
// RL24 - entry address is base plus entry index times sixteen
// RL25 - reset clears in-progress flags and suppression bits
`timescale 1ns/10ps
`default_nettype none
`include "mcd_cfg.svh"

module mchk_dispatch #(
   parameter int         ADDR_W     = 48,
   parameter int         PAGE_SHIFT = 13,
   parameter int         ENTRIES    = 2048,
   parameter logic [7:0] HALT_DBL   = 8'h01 // arbitrary code
) (
   // clock and reset
   input  wire logic                         clk_in,
   input  wire logic                         rst_in,
   input  wire logic                         ce_in,
   // processor context
   input  wire logic [4:0]                   ipl_in,
   input  wire logic [63:0]                  next_pc_in,
   input  wire logic                         retry_ok_in,
   // error detection strobes
   input  wire logic                         proc_uerr_nm_in,
   input  wire logic                         proc_uerr_in,
   input  wire logic                         sys_uerr_in,
   input  wire logic                         proc_cor_nm_in,
   input  wire logic                         proc_cor_in,
   input  wire logic                         sys_cor_in,
   input  wire logic                         deliver_fail_in,
   // fault and trap requests
   input  wire logic                         fault_req_in,
   input  wire mcd_pkg::trap_kind_t          fault_kind_in,
   output logic                              fault_ack_out,
   // software controls
   input  wire logic                         drain_aborts_in,
   input  wire logic                         clr_mchk_in,
   input  wire logic                         clr_sys_cor_in,
   input  wire logic                         clr_proc_cor_in,
   input  wire logic                         sup_wr_in,
   input  wire logic [1:0]                   sup_val_in,
   input  wire logic [ADDR_W-PAGE_SHIFT-1:0] vtb_pfn_in,
   // logout frame description
   input  wire logic                         frame_build_in,
   input  wire logic [63:0]                  frame_off_in,
   input  wire mcd_pkg::frame_len_t          frame_len_in,
   // vector block read port
   output logic                              mem_req_out,
   output logic      [ADDR_W-1:0]            mem_addr_out,
   input  wire logic                         mem_ack_in,
   input  wire logic [63:0]                  mem_rdata_in,
   // results
   output logic                              dispatch_valid_out,
   output mcd_pkg::dispatch_t                dispatch_out,
   output mcd_pkg::frame_hdr_t               frame_out,
   output logic      [4:0]                   error_summary_out,
   output logic                              corrected_out,
   output logic                              issue_ok_out,
   output logic                              console_out,
   output logic      [7:0]                   halt_reason_out
);

   // ==========================================
   // state
   mcd_pkg::disp_state_t st_q;
   mcd_pkg::disp_state_t st_d;
   mcd_pkg::dispatch_t   disp_q;
   mcd_pkg::frame_hdr_t  frame_q;
   mcd_pkg::frame_hdr_t  frame_d;
   logic [ADDR_W-1:0]    addr_q;
   logic [1:0]           sup_q;
   logic                 drain_q;
   logic [7:0]           halt_q;

   wire  [5:0]           pend;
   wire  [2:0]           ip;
   wire  [1:0]           sec;

   // ==========================================
   // eligibility and priority
   // bit order is priority order, lowest bit first:
   // 0 proc uncorr nonmask, 1 proc cor nonmask,
   // 2 proc uncorr, 3 sys uncorr, 4 proc cor, 5 sys cor
   wire [5:0] pend_set;
   wire [5:0] pend_clr;
   wire [5:0] mask_ok;
   wire [5:0] elig;
   wire [5:0] grant;
   wire       uerr_det;
   wire       dbl_err;
   wire       idle;
   wire       flt_go;
   wire       ev_go;

   assign uerr_det = proc_uerr_nm_in | proc_uerr_in | sys_uerr_in;
   assign dbl_err  = uerr_det & ip[`ES_MCHK_IP]; // RL9

   // an uncorrectable error seen during a check escalates instead
   assign pend_set = {sys_cor_in,
                      proc_cor_in,
                      sys_uerr_in & ~ip[`ES_MCHK_IP],
                      proc_uerr_in & ~ip[`ES_MCHK_IP],
                      proc_cor_nm_in,
                      proc_uerr_nm_in & ~ip[`ES_MCHK_IP]};

   // no enable masks a check, only the priority level defers it
   assign mask_ok = {ipl_in < `IPL_SYS_COR,
                     ipl_in < `IPL_MAX,
                     ipl_in < `IPL_MAX,
                     ipl_in < `IPL_MAX,
                     1'b1,
                     1'b1}; // RL1 RL2

   assign elig  = pend & mask_ok;
   assign grant = elig & (~elig + 6'h01);

   assign idle   = (st_q == mcd_pkg::ST_IDLE);
   assign flt_go = idle & fault_req_in;
   assign ev_go  = idle & ~fault_req_in & (|grant);

   // a processor uncorrectable check swallows a pending system uncorrectable check for the same event
   assign pend_clr = {6{ev_go}}
                   & (grant | {2'b00, grant[0] | grant[2], 3'b000}); // RL7

   sticky_flags #(
      .W (6)
   ) u_pend (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .ce_in  (ce_in),
      .set_in (pend_set),
      .clr_in (pend_clr),
      .q_out  (pend)
   );

   // ==========================================
   // kind of the granted event
   wire is_u;
   wire is_pc;
   wire is_sc;
   wire is_cor;
   wire cor_sup;
   wire cor_rep;
   wire deliver;

   assign is_u    = grant[0] | grant[2] | grant[3];
   assign is_pc   = grant[1] | grant[4];
   assign is_sc   = grant[5];
   assign is_cor  = is_pc | is_sc;

   // suppressed or already in progress: corrected but not reported
   assign cor_sup = is_pc ? (sup_q[0] | ip[`ES_PROC_COR_IP])
                          : (sup_q[1] | ip[`ES_SYS_COR_IP]); // RL3 RL11
   assign cor_rep = is_cor & ~cor_sup;
   assign deliver = flt_go | (ev_go & (is_u | cor_rep));

   assign corrected_out = ev_go & is_cor; // RL3

   // ==========================================
   // in-progress and second-error flags
   wire [2:0] ip_set;
   wire [2:0] ip_clr;
   wire [1:0] sec_set;
   wire [1:0] sec_clr;

   assign ip_set = {ev_go & cor_rep & is_pc,
                    ev_go & cor_rep & is_sc,
                    ev_go & is_u}; // RL8 RL10
   assign ip_clr = {clr_proc_cor_in, clr_sys_cor_in, clr_mchk_in}; // RL8 RL10

   sticky_flags #(
      .W (3)
   ) u_ip (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .ce_in  (ce_in),
      .set_in (ip_set),
      .clr_in (ip_clr),
      .q_out  (ip)
   ); // RL25

   // bit 0 proc, bit 1 sys
   assign sec_set = {sys_cor_in & ip[`ES_SYS_COR_IP],
                     (proc_cor_in | proc_cor_nm_in) & ip[`ES_PROC_COR_IP]}; // RL15
   assign sec_clr = {ev_go & cor_rep & is_sc,
                     ev_go & cor_rep & is_pc};

   sticky_flags #(
      .W (2)
   ) u_sec (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .ce_in  (ce_in),
      .set_in (sec_set),
      .clr_in (sec_clr),
      .q_out  (sec)
   );

   assign error_summary_out = {sup_q[1], sup_q[0], ip};

   // ==========================================
   // vector offset and target level
   function automatic logic [14:0] trap_off(input mcd_pkg::trap_kind_t k);
      case (k)
         mcd_pkg::FLT_FEN:     trap_off = `OFF_FEN;
         mcd_pkg::FLT_ACV:     trap_off = `OFF_ACV;
         mcd_pkg::FLT_TNV:     trap_off = `OFF_TNV;
         mcd_pkg::FLT_FOR:     trap_off = `OFF_FOR;
         mcd_pkg::FLT_FOW:     trap_off = `OFF_FOW;
         mcd_pkg::FLT_FOE:     trap_off = `OFF_FOE;
         mcd_pkg::TRP_ARITH:   trap_off = `OFF_ARITH;
         mcd_pkg::TRP_ASYNC_K: trap_off = `OFF_ASYNC_K;
         mcd_pkg::TRP_ASYNC_E: trap_off = `OFF_ASYNC_E;
         mcd_pkg::TRP_ASYNC_S: trap_off = `OFF_ASYNC_S;
         default:              trap_off = `OFF_FEN;
      endcase
   endfunction : trap_off // RL20 RL21 RL22

   wire [14:0]       off_sel;
   wire [4:0]        ipl_sel;
   wire              is_async;
   wire [ADDR_W-1:0] entry_addr;

   assign is_async = (fault_kind_in == mcd_pkg::TRP_ASYNC_K)
                   | (fault_kind_in == mcd_pkg::TRP_ASYNC_E)
                   | (fault_kind_in == mcd_pkg::TRP_ASYNC_S);

   assign off_sel = flt_go                ? trap_off(fault_kind_in) :
                    (grant[0] | grant[2]) ? `OFF_PROC_MCHK :
                    grant[3]              ? `OFF_SYS_MCHK :
                    is_pc                 ? `OFF_PROC_COR : `OFF_SYS_COR;

   // faults and traps keep the level; async traps drop to 2
   assign ipl_sel = flt_go ? (is_async ? `IPL_ASYNC : ipl_in) :
                    is_sc  ? `IPL_SYS_COR : `IPL_MAX; // RL20 RL21 RL22 RL1

   vec_entry_addr #(
      .ADDR_W     (ADDR_W),
      .PAGE_SHIFT (PAGE_SHIFT)
   ) u_addr (
      .pfn_in   (vtb_pfn_in),
      .off_in   (off_sel),
      .addr_out (entry_addr)
   ); // RL24 RL17

   // ==========================================
   // logout frame header
   wire [31:0] cpu_off;
   wire [31:0] sys_off;
   wire [31:0] frm_size;
   wire        sec_bit;
   wire        frame_use;

   // zero-length sections give the equal offsets that mark absence
   assign cpu_off  = `FRM_FW_OFF + frame_len_in.fw_len; // RL16
   assign sys_off  = cpu_off + frame_len_in.cpu_len; // RL16
   assign frm_size = sys_off + frame_len_in.sys_len; // RL13 RL16
   assign sec_bit  = is_pc ? sec[0] : sec[1];
   assign frame_use = ~flt_go & frame_build_in;

   always_comb begin
      frame_d         = '0;
      frame_d.size    = frm_size;
      frame_d.cpu_off = cpu_off;
      frame_d.sys_off = sys_off;
      if (is_cor) begin
         frame_d.flags[`FLG_RETRY]  = 1'b1; // RL14
         frame_d.flags[`FLG_SECOND] = sec_bit; // RL15
      end else begin
         frame_d.flags[`FLG_RETRY]  = retry_ok_in; // RL6
      end
   end

   // ==========================================
   // dispatch sequencer
   always_comb begin
      st_d = st_q;
      case (st_q)
         mcd_pkg::ST_IDLE:    if (deliver) st_d = mcd_pkg::ST_RD_VEC;
         mcd_pkg::ST_RD_VEC:  if (mem_ack_in) st_d = mcd_pkg::ST_RD_PARM;
         mcd_pkg::ST_RD_PARM: if (mem_ack_in) st_d = mcd_pkg::ST_DONE;
         mcd_pkg::ST_DONE:    st_d = mcd_pkg::ST_IDLE;
         mcd_pkg::ST_CONSOLE: st_d = mcd_pkg::ST_CONSOLE;
         default:             st_d = mcd_pkg::ST_IDLE;
      endcase
      if (dbl_err | deliver_fail_in) begin
         st_d = mcd_pkg::ST_CONSOLE; // RL9
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_q <= mcd_pkg::ST_IDLE;
      end else if (ce_in) begin
         st_q <= st_d;
      end
   end

   // entry fetch: handler address first, parameter eight bytes on
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         addr_q <= '0;
      end else if (ce_in) begin
         if (idle & deliver) begin
            addr_q <= entry_addr; // RL23
         end else if ((st_q == mcd_pkg::ST_RD_VEC) & mem_ack_in) begin
            addr_q <= addr_q + `OFF_PARAM; // RL18
         end
      end
   end

   assign mem_req_out  = (st_q == mcd_pkg::ST_RD_VEC)
                       | (st_q == mcd_pkg::ST_RD_PARM); // RL23
   assign mem_addr_out = addr_q;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         disp_q  <= '0;
         frame_q <= '0;
      end else if (ce_in) begin
         if (idle & deliver) begin
            disp_q.saved_pc   <= next_pc_in; // RL4
            disp_q.ipl        <= ipl_sel;
            disp_q.kernel     <= 1'b1; // RL2 RL20
            disp_q.logout_ptr <= frame_use ? frame_off_in : `LOGOUT_NONE; // RL12
            frame_q           <= frame_d; // RL11
         end
         if ((st_q == mcd_pkg::ST_RD_VEC) & mem_ack_in) begin
            disp_q.handler_pc <= mem_rdata_in; // RL18
         end
         if ((st_q == mcd_pkg::ST_RD_PARM) & mem_ack_in) begin
            disp_q.param <= mem_rdata_in; // RL18
         end
      end
   end

   assign dispatch_valid_out = (st_q == mcd_pkg::ST_DONE);
   assign dispatch_out       = disp_q;
   assign frame_out          = frame_q;
   assign fault_ack_out      = flt_go;

   // ==========================================
   // suppression, drain and console
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sup_q   <= 2'b00; // RL25
         drain_q <= 1'b0;
         halt_q  <= 8'h00;
      end else if (ce_in) begin
         if (sup_wr_in) begin
            sup_q <= sup_val_in;
         end
         drain_q <= drain_aborts_in | (drain_q & ((|elig) | ~idle)); // RL5
         if ((dbl_err | deliver_fail_in) & (st_q != mcd_pkg::ST_CONSOLE)) begin
            halt_q <= HALT_DBL; // RL9
         end
      end
   end

   assign console_out     = (st_q == mcd_pkg::ST_CONSOLE);
   assign halt_reason_out = halt_q;
   assign issue_ok_out    = idle & ~drain_aborts_in
                          & ~(drain_q & (|elig)); // RL5

   // ==========================================
   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   dbl_err_halt_a: assert property (ce_in && dbl_err |=> console_out && halt_reason_out == HALT_DBL) // RL9
      else $error("double error did not halt");
   mchk_ip_set_a: assert property (ce_in && ev_go && is_u |=> error_summary_out[0]) // RL8
      else $error("check started without in-progress flag");
   saved_pc_a: assert property (ce_in && idle && deliver |=> dispatch_out.saved_pc == $past(next_pc_in)) // RL4
      else $error("saved pc wrong");
   cor_flags_a: assert property (dispatch_valid_out && frame_out.flags[30] |-> frame_out.flags[31]) // RL14
      else $error("second error without retry flag");
   low_flags_a: assert property (dispatch_valid_out |-> frame_out.flags[29:0] == 30'h0) // RL15
      else $error("low frame flags not zero");
   mask_defer_a: assert property (ev_go && (grant[2] || grant[3] || grant[4]) |-> ipl_in < 5'h1f) // RL1
      else $error("maskable check at level 31");
   drain_hold_a: assert property (drain_q && (|elig) |-> !issue_ok_out) // RL5
      else $error("issue during drain");
   suppress_a: assert property (ce_in && ev_go && is_cor && cor_sup |=> st_q == mcd_pkg::ST_IDLE // RL3
      || st_q == mcd_pkg::ST_CONSOLE)
      else $error("suppressed correction was reported");
   entry_fetch_a: assert property (ce_in && idle && deliver && !dbl_err && !deliver_fail_in // RL23
      |=> mem_req_out && mem_addr_out[3:0] == 4'h0)
      else $error("entry not fetched");

endmodule : mchk_dispatch

`default_nettype wire

// >>> test/vec_mem_model.sv
// vector block memory that answers the unit's entry reads
`timescale 1ns/10ps
`default_nettype none

module vec_mem_model (
   // clock
   input  wire logic        clk_in,
   // read port
   input  wire logic        mem_req_in,
   input  wire logic [47:0] mem_addr_in,
   input  wire logic        slow_in,
   output logic             mem_ack_out,
   output logic      [63:0] mem_rdata_out
);
   logic toggle_q = 1'b0;

   initial begin
      mem_ack_out = 1'b0;
      mem_rdata_out = 64'h0;
   end

   // ====================
   // slow mode answers every other cycle; idle data reads back inverted
   always @(posedge clk_in) begin
      #1;
      toggle_q = ~toggle_q;
      if (mem_req_in && (!slow_in || toggle_q)) begin
         mem_ack_out = 1'b1;
         mem_rdata_out = {16'hc3c3, mem_addr_in};
      end else begin
         mem_ack_out = 1'b0;
         mem_rdata_out = ~mem_rdata_out;
      end
   end
endmodule : vec_mem_model

`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the machine check and vector dispatch unit
`timescale 1ns/10ps
`default_nettype none

module testbench;
   logic                clk_in = 1'b0, rst_in = 1'b1, retry = 1'b0, freq = 1'b0, drain = 1'b0;
   logic                sup_wr = 1'b0, fbuild = 1'b1, slow = 1'b0, dfail = 1'b0, sc, sd;
   logic                fack, mreq, mack, dvalid, corr, issue, console;
   logic [4:0]          ipl = 5'h1f, esum;
   logic [5:0]          ev = 6'h0;
   logic [2:0]          clr = 3'h0;
   logic [1:0]          sup = 2'h0;
   logic [34:0]         page_frame_number = 35'h0;
   logic [47:0]         maddr, base;
   logic [63:0]         pc = 64'h0, foff = 64'h0, rdata;
   logic [7:0]          halt;
   logic [14:0]         toff [10] = '{15'h0010, 15'h0080, 15'h0090, 15'h00a0, 15'h00b0, 15'h00c0,
                                      15'h0200, 15'h0240, 15'h0250, 15'h0260};
   logic [14:0]         eoff [6] = '{15'h0670, 15'h0670, 15'h0660, 15'h0630, 15'h0630, 15'h0620};
   mcd_pkg::trap_kind_t fkind = mcd_pkg::FLT_FEN;
   mcd_pkg::frame_len_t fl = '0;
   mcd_pkg::dispatch_t  dout;
   mcd_pkg::frame_hdr_t frm, old;
   int                  seed = 61903, mismatches = 0, check_count = 0, i, k;

   always #5 clk_in = ~clk_in;

   mchk_dispatch #(.ADDR_W(48), .PAGE_SHIFT(13), .ENTRIES(2048), .HALT_DBL(8'h5a)) u_dut (
      .clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .ipl_in(ipl), .next_pc_in(pc), .retry_ok_in(retry),
      .proc_uerr_nm_in(ev[0]), .proc_uerr_in(ev[1]), .sys_uerr_in(ev[2]), .proc_cor_nm_in(ev[3]),
      .proc_cor_in(ev[4]), .sys_cor_in(ev[5]), .deliver_fail_in(dfail), .fault_req_in(freq),
      .fault_kind_in(fkind), .fault_ack_out(fack), .drain_aborts_in(drain), .clr_mchk_in(clr[0]),
      .clr_sys_cor_in(clr[1]), .clr_proc_cor_in(clr[2]), .sup_wr_in(sup_wr), .sup_val_in(sup),
      .vtb_pfn_in(page_frame_number), .frame_build_in(fbuild), .frame_off_in(foff), .frame_len_in(fl),
      .mem_req_out(mreq), .mem_addr_out(maddr), .mem_ack_in(mack), .mem_rdata_in(rdata),
      .dispatch_valid_out(dvalid), .dispatch_out(dout), .frame_out(frm), .error_summary_out(esum),
      .corrected_out(corr), .issue_ok_out(issue), .console_out(console), .halt_reason_out(halt));
   vec_mem_model u_mem (.clk_in(clk_in), .mem_req_in(mreq), .mem_addr_in(maddr), .slow_in(slow),
      .mem_ack_out(mack), .mem_rdata_out(rdata));

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : step

   task automatic pulse(input logic [5:0] e);
      ev = e;
      step(1);
      ev = 6'h0;
   endtask : pulse

   task automatic clear(input logic [2:0] c);
      clr = c;
      step(1);
      clr = 3'h0;
   endtask : clear

   // notes any correction pulse or dispatch over n cycles
   task automatic watch(input int n);
      sc = 1'b0;
      sd = 1'b0;
      for (int j = 0; j < n && !sd; j++) begin
         #1;
         if (corr === 1'b1) sc = 1'b1;
         if (dvalid === 1'b1) sd = 1'b1;
         step(1);
      end
   endtask : watch

   task automatic disp(input logic [14:0] off, input logic [4:0] tipl, input logic [63:0] lptr);
      watch(30);
      if (sd !== 1'b1) begin
         chk(sd, 1'b1);
         conclude();
      end
      base = {page_frame_number, 13'h0} + {33'h0, off};
      chk(dout.handler_pc, {16'hc3c3, base});
      chk(dout.param, {16'hc3c3, base + 48'h8});
      chk(dout.ipl, tipl);
      chk(dout.kernel, 1'b1);
      chk(dout.logout_ptr, lptr);
   endtask : disp

   initial begin
      step(10);
      rst_in = 1'b0;
      chk(esum, 5'h0);
      for (k = 0; k < 10; k++) begin
         page_frame_number = 35'({$random(seed), $random(seed)});
         slow = k[0];
         ipl = 5'($random(seed));
         fkind = mcd_pkg::trap_kind_t'(k);
         freq = 1'b1;
         @(negedge clk_in);
         chk(fack, 1'b1);
         step(1);
         freq = 1'b0;
         disp(toff[k], (k > 6) ? 5'h02 : ipl, 64'hffff_ffff_ffff_ffff);
      end
      $display("test faults done");
      for (i = 0; i < 6; i++) begin
         ipl = (i == 5) ? 5'h14 : 5'h1f;
         pc = {$random(seed), $random(seed)};
         retry = 1'($random(seed));
         slow = 1'($random(seed));
         fbuild = (i != 2);
         foff = 64'({$random(seed)} % 4096 * 8);
         fl.fw_len = (i == 1) ? 32'h0 : 32'({$random(seed)} % 4 * 8);
         fl.cpu_len = 32'({$random(seed)} % 4 * 8);
         fl.sys_len = (i == 4) ? 32'h0 : 32'({$random(seed)} % 4 * 8);
         drain = (i == 0);
         ev = 6'h1 << i;
         #1;
         if (i == 0) chk(issue, 1'b0);
         step(1);
         ev = 6'h0;
         drain = 1'b0;
         if (i == 0) chk(issue, 1'b0);
         if (i != 0 && i != 3) begin
            watch(8);
            chk(sd, 1'b0);
            ipl = (i == 5) ? 5'h13 : 5'h1e;
         end
         disp(eoff[i], (i == 5) ? 5'h14 : 5'h1f, fbuild ? foff : 64'hffff_ffff_ffff_ffff);
         chk(dout.saved_pc, pc);
         chk(issue, 1'b1);
         if (fbuild) begin
            chk(frm.flags, (i > 2) ? 32'h8000_0000 : {retry, 31'h0});
            chk(frm.cpu_off, 32'h10 + fl.fw_len);
            chk(frm.sys_off, 32'h10 + fl.fw_len + fl.cpu_len);
            chk(frm.size, 32'h10 + fl.fw_len + fl.cpu_len + fl.sys_len);
         end
         k = (i < 3) ? 0 : ((i == 5) ? 1 : 2);
         chk(esum, 5'h1 << k);
         clear(3'h1 << k);
         chk(esum, 5'h0);
      end
      $display("test machine checks done");
      ipl = 5'h1e;
      pulse(6'h06);
      disp(15'h0670, 5'h1f, foff);
      clear(3'h1);
      watch(10);
      chk(sd, 1'b0);
      pulse(6'h08);
      disp(15'h0630, 5'h1f, foff);
      old = frm;
      pulse(6'h08);
      watch(8);
      chk(sc, 1'b1);
      chk(sd, 1'b0);
      chk(frm[127:64], old[127:64]);
      chk(frm[63:0], old[63:0]);
      clear(3'h4);
      pulse(6'h08);
      disp(15'h0630, 5'h1f, foff);
      chk(frm.flags, 32'hc000_0000);
      clear(3'h4);
      $display("test second correction done");
      for (k = 0; k < 2; k++) begin
         sup = 2'h1 << k;
         sup_wr = 1'b1;
         step(1);
         sup_wr = 1'b0;
         ipl = 5'h13;
         pulse(k ? 6'h20 : 6'h08);
         watch(8);
         chk(sc, 1'b1);
         chk(sd, 1'b0);
         chk(esum, 5'h8 << k);
      end
      sup = 2'h3;
      sup_wr = 1'b1;
      step(1);
      sup_wr = 1'b0;
      $display("test suppression done");
      pulse(6'h01);
      disp(15'h0670, 5'h1f, foff);
      pulse(6'h04);
      chk(console, 1'b1);
      chk(halt, 8'h5a);
      rst_in = 1'b1;
      step(1);
      rst_in = 1'b0;
      chk(esum, 5'h0);
      chk(console, 1'b0);
      dfail = 1'b1;
      step(1);
      dfail = 1'b0;
      chk(console, 1'b1);
      $display("test console entry done");
      conclude();
   end
endmodule : testbench

`default_nettype wire
